// [src/ptr_addr_mux.sv]
// Table address former and program memory read port selector
`timescale 1ns/1ps
module ptr_addr_mux
  import ptr_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  input  wire logic [LO_PTR_W-1:0] ptr_lo,
  input  wire logic [HI_PTR_W-1:0] ptr_hi,
  input  wire logic                last_page,
  input  wire logic                table_cycle,
  input  wire logic [AW-1:0]       fetch_addr,
  output logic      [AW-1:0]       mem_addr
);
  initial begin
    if (AW != LO_PTR_W + HI_PTR_W) $error("ptr_addr_mux: AW must equal pointer width");
  end

  logic [HI_PTR_W-1:0] hi_sel;
  always_comb begin
    hi_sel   = last_page ? LAST_PAGE : ptr_hi;
    mem_addr = table_cycle ? {hi_sel, ptr_lo} : fetch_addr;
  end
endmodule

// [src/ptr_pkg.sv]
// Constants and types for the program memory table read block
// Operation
// - The table address is eleven bits, low eight from the low pointer, top three from the high pointer.
// - A table read writes the low byte of the addressed word to the data memory location in the operand.
// - A table read loads the high byte of the addressed word into the table high-byte latch.
// - High-byte bit positions with no stored memory bit behind them read as zero.
// - The last-page form forces address bits ten to eight to ones.
// - The high-byte latch ignores software writes and changes only on a table read.
// - Each table read takes two instruction cycles and stalls the instruction flow for one.
// - The program memory holds 2K words of 16 bits addressed by the table address.
package ptr_pkg;
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned LO_PTR_W    = 8;
  localparam int unsigned HI_PTR_W    = 3;
  localparam int unsigned MEM_WORDS   = 2048;
  localparam int unsigned STORED_HI_W = 8;
  localparam logic [2:0]  LAST_PAGE   = 3'h7;
  localparam logic [7:0]  HIGH_RST    = 8'h00;
  localparam logic [7:0]  DADDR_RST   = 8'h00;

  typedef enum logic [0:0] {
    PTR_FETCH = 1'b0,
    PTR_TABLE = 1'b1
  } ptr_state_e;
endpackage

// [src/ptr_table_read.sv]
// Program memory table read unit
`timescale 1ns/1ps
module ptr_table_read
  import ptr_pkg::*;
#(
  parameter int unsigned STORED_W = STORED_HI_W,
  parameter int unsigned DADDR_W  = 8
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire logic                tab_req,
  input  wire logic                tab_last,
  input  wire logic [DADDR_W-1:0]  tab_dest,
  input  wire logic [LO_PTR_W-1:0] ptr_lo,
  input  wire logic [HI_PTR_W-1:0] ptr_hi,
  input  wire logic [ADDR_W-1:0]   fetch_addr,
  input  wire logic [WORD_W-1:0]   mem_rdata,
  input  wire logic                sw_hi_wr,
  input  wire logic [BYTE_W-1:0]   sw_hi_wdata,
  output logic      [ADDR_W-1:0]   mem_addr,
  output logic                     core_stall,
  output logic                     dmem_we,
  output logic      [DADDR_W-1:0]  dmem_addr,
  output logic      [BYTE_W-1:0]   dmem_wdata,
  output logic      [BYTE_W-1:0]   table_high_byte_latch
);
  initial begin
    if (STORED_W == 0 || STORED_W > BYTE_W) $error("ptr_table_read: STORED_W out of range");
    if (DADDR_W == 0) $error("ptr_table_read: DADDR_W must be nonzero");
    if (MEM_WORDS != (1 << ADDR_W)) $error("ptr_table_read: memory size mismatch");
  end

  ptr_state_e          state_r, state_nxt;
  logic [DADDR_W-1:0]  dest_r, dest_nxt;
  logic                last_r, last_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic [ADDR_W-1:0]   addr_comb;
  logic                stall_r, stall_nxt;
  logic                we_r, we_nxt;
  logic [DADDR_W-1:0]  waddr_r, waddr_nxt;
  logic [BYTE_W-1:0]   wdata_r, wdata_nxt;
  logic [BYTE_W-1:0]   high_r, high_nxt;
  logic [BYTE_W-1:0]   high_mask;

  // Address path kept combinational inside the submodule, registered here
  ptr_addr_mux #(.AW(ADDR_W)) u_mux (
    .ptr_lo      (ptr_lo),
    .ptr_hi      (ptr_hi),
    .last_page   (state_nxt == PTR_TABLE ? last_nxt : 1'b0),
    .table_cycle (state_nxt == PTR_TABLE),
    .fetch_addr  (fetch_addr),
    .mem_addr    (addr_comb)
  );

  always_comb begin
    high_mask = BYTE_W'((1 << STORED_W) - 1);
  end

  // Memory is read one cycle after the address is presented
  always_comb begin
    state_nxt = state_r;
    dest_nxt  = dest_r;
    last_nxt  = last_r;
    stall_nxt = 1'b0;
    we_nxt    = 1'b0;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    high_nxt  = high_r;
    case (state_r)
      PTR_FETCH: begin
        if (tab_req) begin
          state_nxt = PTR_TABLE;
          dest_nxt  = tab_dest;
          last_nxt  = tab_last;
          stall_nxt = 1'b1;
        end
      end
      PTR_TABLE: begin
        state_nxt = PTR_FETCH;
        we_nxt    = 1'b1;
        waddr_nxt = dest_r;
        wdata_nxt = mem_rdata[BYTE_W-1:0];
        high_nxt  = mem_rdata[WORD_W-1:BYTE_W] & high_mask;
      end
      default: state_nxt = PTR_FETCH;
    endcase
    addr_nxt = addr_comb;
  end

  // Software write strobe deliberately has no effect on the latch
  logic unused_sw;
  always_comb unused_sw = sw_hi_wr ^ (|sw_hi_wdata);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PTR_FETCH;
      dest_r  <= DADDR_RST;
      last_r  <= 1'b0;
      addr_r  <= '0;
      stall_r <= 1'b0;
      we_r    <= 1'b0;
      waddr_r <= DADDR_RST;
      wdata_r <= '0;
      high_r  <= HIGH_RST;
    end else if (clk_en) begin
      state_r <= state_nxt;
      dest_r  <= dest_nxt;
      last_r  <= last_nxt;
      addr_r  <= addr_nxt;
      stall_r <= stall_nxt;
      we_r    <= we_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      high_r  <= high_nxt;
    end
  end

  assign mem_addr              = addr_r;
  assign core_stall            = stall_r;
  assign dmem_we               = we_r;
  assign dmem_addr             = waddr_r;
  assign dmem_wdata            = wdata_r;
  assign table_high_byte_latch = high_r;

  sequence s_req;
    clk_en && state_r == PTR_FETCH && tab_req;
  endsequence

  // Extra cycle in which the table word stands on the read port
  sequence s_table;
    clk_en && state_r == PTR_TABLE;
  endsequence

  // Low enable must freeze everything, or a stalled core would lose a read
  sequence s_frozen;
    !clk_en;
  endsequence

  chk_table_two_cycles: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_req |=> (state_r == PTR_TABLE && stall_r))
    else $error("table read did not enter its extra cycle");

  chk_stall_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (stall_r && clk_en) |=> !stall_r)
    else $error("stall lasted more than one cycle");

  chk_stall_ignores_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_table ##0 tab_req) |=> !core_stall && state_r == PTR_FETCH)
    else $error("request taken during the extra cycle");

  chk_port_table_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_req |=> mem_addr == {($past(tab_last) ? LAST_PAGE : $past(ptr_hi)), $past(ptr_lo)})
    else $error("table address wrong");

  chk_last_page_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_req ##0 tab_last) |=> mem_addr[ADDR_W-1:LO_PTR_W] == LAST_PAGE)
    else $error("last page bits not forced");

  chk_low_to_dmem: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_table |=> dmem_we && dmem_addr == $past(dest_r)
      && dmem_wdata == $past(mem_rdata[BYTE_W-1:0]))
    else $error("low byte not written");

  chk_we_single_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dmem_we && clk_en) |=> !dmem_we && $stable(dmem_addr) && $stable(dmem_wdata))
    else $error("data memory write not a single pulse");

  chk_no_write_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && state_r == PTR_FETCH) |=> !dmem_we)
    else $error("data memory written outside a table read");

  chk_high_latch_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_table |=>
      table_high_byte_latch == ($past(mem_rdata[WORD_W-1:BYTE_W]) & high_mask))
    else $error("high byte not latched");

  chk_high_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (table_high_byte_latch & ~high_mask) == '0)
    else $error("unused high bits not zero");

  chk_high_only_table: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(clk_en && state_r == PTR_TABLE) |=> $stable(table_high_byte_latch))
    else $error("high latch changed outside a table read");

  chk_fetch_resumes: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_table ##0 !tab_req) |=> mem_addr == $past(fetch_addr))
    else $error("fetch did not resume");

  chk_freeze_state: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_frozen |=> $stable(state_r) && $stable(mem_addr) && $stable(core_stall)
      && $stable(dmem_we) && $stable(table_high_byte_latch))
    else $error("state moved while clock enable low");
endmodule

// [tb/program_memory_table_read_tb.sv]
// Self-checking bench for the table read unit
`timescale 1ns/1ps
module program_memory_table_read_tb
  import ptr_pkg::*;
;
  logic        core_clk, rst_n, tab_req, tab_last, sw_hi_wr, core_stall, dmem_we, st_d;
  logic [7:0]  tab_dest, ptr_lo, sw_hi_wdata, dmem_addr, dmem_wdata, table_high_byte_latch;
  logic [2:0]  ptr_hi;
  logic [10:0] fetch_addr, mem_addr, fa_d, a;
  logic [15:0] mem_rdata;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  logic        mon_en;
  logic        clk_en, last_v;
  logic [7:0]  lo_v, dest_v;
  logic [2:0]  hi_v;
  int          n_errors, total_checks;

  ptr_table_read #(.STORED_W(6), .DADDR_W(8)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .tab_req(tab_req),
    .tab_last(tab_last), .tab_dest(tab_dest), .ptr_lo(ptr_lo), .ptr_hi(ptr_hi),
    .fetch_addr(fetch_addr), .mem_rdata(mem_rdata), .sw_hi_wr(sw_hi_wr),
    .sw_hi_wdata(sw_hi_wdata), .mem_addr(mem_addr), .core_stall(core_stall),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .table_high_byte_latch(table_high_byte_latch));

  ptr_mem_model mem_u (.mem_addr(mem_addr), .mem_rdata(mem_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    #4000;
    n_errors++;
    conclude();
  end

  // Checks trail the driver by registered output latency
  always @(posedge core_clk) begin
    fa_d <= fetch_addr;
    st_d <= core_stall;
    if (mon_en) begin
      if (core_stall === 1'b1) check(16'(mem_addr), 16'(exp_q[0][10:0]));
      else check(16'(mem_addr), 16'(fa_d));
      if (dmem_we === 1'b1) begin
        e = exp_q.pop_front();
        check(16'({st_d, core_stall}), 16'h0002);
        check({dmem_addr, dmem_wdata}, e[34:19]);
        check(16'(table_high_byte_latch), 16'(e[18:11]));
      end
    end
  end

  initial begin
    {rst_n, tab_req, tab_last, sw_hi_wr, mon_en} = '0;
    clk_en = 1'b1;
    {tab_dest, ptr_lo, ptr_hi, sw_hi_wdata, fetch_addr} = '0;
    void'($urandom(32'he1bc));
    repeat (8) @(posedge core_clk);
    check({table_high_byte_latch, dmem_wdata}, 16'h0000);
    $display("reset test done");
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    mon_en <= 1'b1;
    // Single requester, so the shared latch is never overwritten behind a reader
    for (int i = 0; i < 120; i++) begin
      @(posedge core_clk);
      lo_v = 8'($urandom);
      hi_v = 3'($urandom);
      last_v = 1'($urandom);
      dest_v = 8'($urandom);
      fetch_addr <= 11'($urandom);
      sw_hi_wr <= 1'($urandom);
      sw_hi_wdata <= 8'($urandom);
      ptr_lo <= lo_v;
      ptr_hi <= hi_v;
      tab_dest <= dest_v;
      tab_last <= last_v;
      // Odd slots fall in the stall cycle and must be ignored
      tab_req <= (i % 2 == 0) ? 1'b1 : 1'($urandom);
      if (i % 2 == 0) begin
        // Pointers are presented together with the request
        a = {last_v ? LAST_PAGE : hi_v, lo_v};
        exp_q.push_back({dest_v, a[7:0] ^ 8'h3c, (a[7:0] ^ {a[10:8], 5'h15}) & 8'h3f, a});
      end
    end
    @(posedge core_clk);
    tab_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(16'(exp_q.size()), 16'h0000);
    $display("table read test done");
    // Clock enable low: a request and a new fetch address must not move anything
    a = fetch_addr;
    mon_en <= 1'b0;
    clk_en <= 1'b0;
    tab_req <= 1'b1;
    fetch_addr <= 11'h5a5;
    repeat (3) @(posedge core_clk);
    check(16'({core_stall, dmem_we}), 16'h0000);
    check(16'(mem_addr), 16'(a));
    clk_en <= 1'b1;
    tab_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(16'(mem_addr), 16'h05a5);
    $display("freeze test done");
    conclude();
  end
endmodule

// [tb/ptr_mem_model.sv]
// Behavioural program memory holding a fixed data pattern
`timescale 1ns/1ps
module ptr_mem_model
  import ptr_pkg::*;
(
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic      [WORD_W-1:0] mem_rdata
);
  // 2K words of 16 bits; settles before the next edge, like the registered port
  always_comb begin
    mem_rdata = {mem_addr[7:0] ^ {mem_addr[10:8], 5'h15}, mem_addr[7:0] ^ 8'h3c};
  end
endmodule
